// ---- core/cam_eval_params.svh ----
// constants of the safe cam evaluator: enable word fields and counts
// assumes inclusion by the package and by the checker module
`ifndef CAM_EVAL_PARAMS_SVH
`define CAM_EVAL_PARAMS_SVH
`define SYNC_ENABLE_BIT    7
`define PAIR_ENABLE_LSB    8
`define PAIR_ENABLE_MSB    15
`define NUM_CAM_PAIRS      4
`define NUM_PAIR_OUTPUTS   8
`define NUM_TRACK_CAMS     30
`define CAM_INDEX_WIDTH    5
`define NUM_TRACKS         4
`define RANGE_CODE_WIDTH   4
`define ASSIGN_WIDTH       9
`define MAX_RANGE_CODE     14
`define TRACK_DIGIT_WEIGHT 100
`define RANGE_BEYOND_LAST  4'hF
`endif

// ---- core/cam_eval_pkg.sv ----
// types shared by the cam evaluator, its config memory and its sync stage
// assumes cam_eval_params.svh is on the include path
`include "cam_eval_params.svh"
package cam_eval_pkg;
   typedef logic signed [31:0] position_t;
   typedef logic signed [33:0] wide_pos_t; // room for position plus two tolerances

   typedef struct packed {
      position_t                   plus_pos;
      position_t                   minus_pos;
      logic [`ASSIGN_WIDTH-1:0]    assignment;
   } cam_config_t;

   typedef struct packed {
      logic                        valid;
      logic [1:0]                  track;
      logic [`RANGE_CODE_WIDTH-1:0] code;
   } assign_dec_t;

   typedef struct packed {
      logic [`NUM_PAIR_OUTPUTS-1:0]                        pair;
      logic [`NUM_TRACKS-1:0]                              flags;
      logic [`NUM_TRACKS-1:0][`RANGE_CODE_WIDTH-1:0]       ranges;
   } channel_result_t;

   typedef enum logic [3:0] {
      S_IDLE    = 4'h1,
      S_FETCH   = 4'h2,
      S_STEP    = 4'h4,
      S_PUBLISH = 4'h8
   } scan_state_t;

   typedef struct packed {
      scan_state_t                      st;
      logic                             checking;
      logic [`CAM_INDEX_WIDTH-1:0]      idx;
      position_t                        pos;
      logic [`NUM_PAIR_OUTPUTS-1:0]     pair_hyst;
      logic [`NUM_TRACK_CAMS-1:0]       track_hyst;
      channel_result_t                  acc;
      logic [`NUM_TRACKS-1:0]           have;
      position_t [`NUM_TRACKS-1:0]      best_minus;
      logic                             err;
      channel_result_t                  diag;
      channel_result_t                  synced;
      logic                             param_error;
      logic                             check_done;
      logic                             cams_valid;
      logic                             mismatch;
   } eval_state_t;
endpackage

// ---- core/cam_config_mem.sv ----
// small memory holding one configuration word per cam
// assumes one writer; read data appear one clock after the index
`timescale 1ns/1ps
module cam_config_mem
   import cam_eval_pkg::*;
#(
   parameter int WIDTH = $bits(cam_config_t),
   parameter int DEPTH = `NUM_TRACK_CAMS,
   parameter int AW    = `CAM_INDEX_WIDTH
) (
   input  wire logic             i_clock,
   input  wire logic             i_write,
   input  wire logic [AW-1:0]    i_write_index,
   input  wire logic [WIDTH-1:0] i_write_data,
   input  wire logic [AW-1:0]    i_read_index,
   output logic      [WIDTH-1:0] o_read_data
);
   logic [WIDTH-1:0] mem_reg [DEPTH];

   // writes past the last cam are dropped rather than aliased
   always_ff @(posedge i_clock) begin
      if (i_write && (i_write_index < AW'(DEPTH))) begin
         mem_reg[i_write_index] <= i_write_data;
      end
      o_read_data <= mem_reg[i_read_index];
   end
endmodule // cam_config_mem

// ---- core/cam_channel_sync.sv ----
// combines this channel's cam results with the redundant channel's
// assumes both result sets are stable while this stage is sampled
`timescale 1ns/1ps
module cam_channel_sync
   import cam_eval_pkg::*;
(
   input  wire logic            i_pair_sync,
   input  wire channel_result_t i_own,
   input  wire channel_result_t i_other,
   output channel_result_t      o_synced
);
   // pair cams only when enabled, tracks always; a zero is the safe value
   always_comb begin
      o_synced = i_own;
      if (i_pair_sync) begin
         o_synced.pair = i_own.pair & i_other.pair;
      end
      o_synced.flags = i_own.flags & i_other.flags;
      for (int t = 0; t < `NUM_TRACKS; t++) begin
         if ((i_own.ranges[t] != i_other.ranges[t]) &&
             (i_own.flags[t] != i_other.flags[t]) && i_own.flags[t]) begin
            o_synced.ranges[t] = i_other.ranges[t];
         end
      end
   end
endmodule // cam_channel_sync

// ---- core/safe_position_cam_evaluator.sv ----
// per-axis safe cam evaluator: pair mode and track mode, boot check
// assumes the config memory is loaded before the boot check pulse and
// that one monitoring tick pulse arrives per monitoring clock cycle
`timescale 1ns/1ps
module safe_position_cam_evaluator
   import cam_eval_pkg::*;
(
   input  wire logic                         i_clock,
   input  wire logic                         i_resetn,
   input  wire logic [15:0]                  i_function_enable,
   input  wire logic [`NUM_TRACK_CAMS-1:0]   i_track_cam_enable,
   input  wire position_t                    i_cam_tolerance,
   input  wire position_t                    i_position_tolerance,
   input  wire position_t                    i_modulo_range,
   input  wire position_t                    i_position,
   input  wire logic                         i_referenced,
   input  wire logic                         i_monitor_tick,
   input  wire logic                         i_boot_check,
   input  wire logic                         i_cfg_write,
   input  wire logic [`CAM_INDEX_WIDTH-1:0]  i_cfg_index,
   input  wire cam_config_t                  i_cfg_data,
   input  wire channel_result_t              i_other_channel,
   output channel_result_t                   o_safe_cam,
   output channel_result_t                   o_diag,
   output logic                              o_cams_valid,
   output logic                              o_param_error,
   output logic                              o_check_done,
   output logic                              o_channel_mismatch,
   output logic                              o_idle
);
   localparam logic [`CAM_INDEX_WIDTH-1:0] LAST_CAM = `CAM_INDEX_WIDTH'(`NUM_TRACK_CAMS - 1);
   localparam logic [`CAM_INDEX_WIDTH-1:0] LAST_PAIR = `CAM_INDEX_WIDTH'(`NUM_CAM_PAIRS - 1);

   eval_state_t     st_reg;
   eval_state_t     st_next;
   cam_config_t     rd_data;
   channel_result_t sync_out;

   // assignment code: hundreds digit is the track, remainder the range code
   function automatic assign_dec_t decode_assign(input logic [`ASSIGN_WIDTH-1:0] a);
      assign_dec_t d;
      logic [`ASSIGN_WIDTH-1:0] hund;
      logic [`ASSIGN_WIDTH-1:0] rest;
      hund = a / `ASSIGN_WIDTH'(`TRACK_DIGIT_WEIGHT);
      rest = a % `ASSIGN_WIDTH'(`TRACK_DIGIT_WEIGHT);
      d.valid = (hund >= `ASSIGN_WIDTH'(1)) && (hund <= `ASSIGN_WIDTH'(`NUM_TRACKS)) &&
                (rest <= `ASSIGN_WIDTH'(`MAX_RANGE_CODE));
      d.track = 2'(hund - `ASSIGN_WIDTH'(1));
      d.code  = rest[`RANGE_CODE_WIDTH-1:0];
      return d;
   endfunction

   // sign-extend a position for margin arithmetic without overflow
   function automatic wide_pos_t widen(input position_t p);
      return wide_pos_t'(p);
   endfunction

   // one word per cam; the scan reads one cam per two clocks
   cam_config_mem u_mem (
      .i_clock       (i_clock),
      .i_write       (i_cfg_write),
      .i_write_index (i_cfg_index),
      .i_write_data  (i_cfg_data),
      .i_read_index  (st_reg.idx),
      .o_read_data   (rd_data)
   );

   // cross-channel combination works on the registered diagnostic view
   cam_channel_sync u_sync (
      .i_pair_sync (i_function_enable[`SYNC_ENABLE_BIT]),
      .i_own       (st_reg.diag),
      .i_other     (i_other_channel),
      .o_synced    (sync_out)
   );

   // next-state logic: boot check scan, evaluation scan, publish
   always_comb begin
      assign_dec_t                   dec;
      logic [`NUM_PAIR_OUTPUTS-1:0]  pair_en;
      logic                          track_mode;
      logic                          sync_on;
      wide_pos_t                     x;
      wide_pos_t                     lo;
      wide_pos_t                     hi;
      wide_pos_t                     tol;
      wide_pos_t                     ptol;
      wide_pos_t                     lim;
      logic                          cam_en;
      logic                          on_plus;
      logic                          on_minus;
      logic                          in_next;
      logic [2:0]                    pb;
      st_next    = st_reg;
      dec        = decode_assign(rd_data.assignment);
      pair_en    = i_function_enable[`PAIR_ENABLE_MSB:`PAIR_ENABLE_LSB];
      track_mode = |i_track_cam_enable;
      sync_on    = i_function_enable[`SYNC_ENABLE_BIT];
      x          = widen(st_reg.pos);
      lo         = widen(rd_data.minus_pos);
      hi         = widen(rd_data.plus_pos);
      ptol       = widen(i_position_tolerance);
      // track mode always carries hysteresis, pair mode only when synced
      tol        = (track_mode || sync_on) ? widen(i_cam_tolerance) : '0;
      lim        = widen(i_modulo_range) - ptol - (sync_on ? widen(i_cam_tolerance) : '0);
      cam_en     = 1'b0;
      on_plus    = 1'b0;
      on_minus   = 1'b0;
      in_next    = 1'b0;
      pb         = {st_reg.idx[1:0], 1'b0};

      // the referenced level qualifies every cam output
      st_next.cams_valid = i_referenced;

      unique case (st_reg.st)
         S_IDLE: begin
            st_next.idx = '0;
            if (i_boot_check) begin
               st_next.st       = S_FETCH;
               st_next.checking = 1'b1;
               // global conditions are judged once, at the start of the check
               st_next.err = ((|pair_en) && track_mode)
                           || (track_mode && (i_modulo_range != '0))
                           || (track_mode && sync_on);
            end else if (i_monitor_tick) begin
               // position frozen so the whole scan sees one sample
               st_next.st         = S_FETCH;
               st_next.checking   = 1'b0;
               st_next.pos        = i_position;
               st_next.acc        = '0;
               st_next.acc.ranges = {`NUM_TRACKS{`RANGE_BEYOND_LAST}};
               st_next.have       = '0;
            end
         end

         S_FETCH: begin
            // memory read index is the current cam; data arrive next clock
            st_next.st = S_STEP;
         end

         S_STEP: begin
            if (st_reg.checking) begin
               cam_en = track_mode ? i_track_cam_enable[st_reg.idx]
                      : ((st_reg.idx <= LAST_PAIR) && (pair_en[pb] || pair_en[pb + 3'd1]));
               if (cam_en) begin
                  if (lo >= hi) begin
                     st_next.err = 1'b1;
                  end
                  if (track_mode) begin
                     if (!dec.valid) begin
                        st_next.err = 1'b1;
                     end
                     if ((hi - lo) < (widen(i_cam_tolerance) + ptol)) begin
                        st_next.err = 1'b1;
                     end
                  end else if (i_modulo_range != '0) begin
                     // both edges must stay clear of the modulo limits
                     if ((lo <= -lim) || (lo >= lim) || (hi <= -lim) || (hi >= lim)) begin
                        st_next.err = 1'b1;
                     end
                  end
               end
            end else if (track_mode) begin
               cam_en = i_track_cam_enable[st_reg.idx] && dec.valid;
               if (cam_en) begin
                  // rising: enter at minus+tol, leave at plus+tol
                  in_next = st_reg.track_hyst[st_reg.idx]
                          ? ((x >= lo) && (x <= hi + tol))
                          : ((x >= lo + tol) && (x <= hi));
                  if (in_next) begin
                     st_next.acc.flags[dec.track] = 1'b1;
                  end
                  // lowest cam not yet passed gives the range code; a cam
                  // still in its switch-on band counts as ahead, so the code
                  // only moves on at the falling edge of the previous cam
                  if ((in_next || (x < lo + tol)) &&
                      (!st_reg.have[dec.track] ||
                       (lo < widen(st_reg.best_minus[dec.track])))) begin
                     st_next.have[dec.track]       = 1'b1;
                     st_next.best_minus[dec.track] = rd_data.minus_pos;
                     st_next.acc.ranges[dec.track] = dec.code;
                  end
               end
               // unassigned or disabled cams leave no trace
               st_next.track_hyst[st_reg.idx] = in_next;
            end else if (st_reg.idx <= LAST_PAIR) begin
               // plus cam above its position, minus cam below its own
               on_plus  = st_reg.pair_hyst[pb] ? (x > hi) : (x > hi + tol);
               on_minus = st_reg.pair_hyst[pb + 3'd1] ? (x < lo + tol) : (x < lo);
               st_next.pair_hyst[pb]        = on_plus && pair_en[pb];
               st_next.pair_hyst[pb + 3'd1] = on_minus && pair_en[pb + 3'd1];
               st_next.acc.pair[pb]         = on_plus && pair_en[pb];
               st_next.acc.pair[pb + 3'd1]  = on_minus && pair_en[pb + 3'd1];
            end

            if (st_reg.idx == LAST_CAM) begin
               if (st_reg.checking) begin
                  // error raised only once the whole check has run
                  st_next.st          = S_IDLE;
                  st_next.param_error = st_next.err;
                  st_next.check_done  = 1'b1;
               end else begin
                  st_next.st = S_PUBLISH;
                  // diag is the hysteresis result before synchronization
                  st_next.diag = st_reg.param_error ? '0 : st_next.acc;
                  if (!track_mode) begin
                     st_next.diag.flags  = '0;
                     st_next.diag.ranges = '0;
                  end
               end
            end else begin
               st_next.idx = st_reg.idx + `CAM_INDEX_WIDTH'(1);
               st_next.st  = S_FETCH;
            end
         end

         S_PUBLISH: begin
            // synchronized view goes to the safe logic program
            st_next.st       = S_IDLE;
            st_next.synced   = st_reg.param_error ? '0 : sync_out;
            // raw disagreement flagged so consumers can filter it
            st_next.mismatch = (st_reg.diag != i_other_channel);
         end
      endcase
   end

   // single state register; config memory keeps its own contents
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         st_reg    <= '0;
         st_reg.st <= S_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // every output is a field of the state register
   assign o_safe_cam         = st_reg.synced;
   assign o_diag             = st_reg.diag;
   assign o_cams_valid       = st_reg.cams_valid;
   assign o_param_error      = st_reg.param_error;
   assign o_check_done       = st_reg.check_done;
   assign o_channel_mismatch = st_reg.mismatch;
   assign o_idle             = st_reg.st[0];
endmodule // safe_position_cam_evaluator

// ---- dv/cam_eval_checker_asserts.sv ----
// checker: scan timing, boot result and channel sync at the evaluator's ports
// assumes a bind to the evaluator and inputs held steady while a scan runs
`timescale 1ns/1ps
`include "cam_eval_params.svh"
module cam_eval_checker
   import cam_eval_pkg::*;
(
   input wire logic                        i_clock,
   input wire logic                        i_resetn,
   input wire logic [15:0]                 i_function_enable,
   input wire logic [`NUM_TRACK_CAMS-1:0]  i_track_cam_enable,
   input wire logic                        i_referenced,
   input wire logic                        i_monitor_tick,
   input wire logic                        i_boot_check,
   input wire channel_result_t             i_other_channel,
   input wire channel_result_t             o_safe_cam,
   input wire channel_result_t             o_diag,
   input wire logic                        o_cams_valid,
   input wire logic                        o_param_error,
   input wire logic                        o_check_done,
   input wire logic                        o_idle
);
   logic idle_reg;
   logic scan_reg;
   logic fin;
   logic ok;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   // boot ends raise idle too; only a finished scan is judged as one
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         idle_reg <= 1'b1;
         scan_reg <= 1'b0;
      end else begin
         idle_reg <= o_idle;
         if (o_idle && (i_boot_check || i_monitor_tick)) scan_reg <= !i_boot_check;
      end
   end
   assign fin = o_idle && !idle_reg && scan_reg;
   assign ok  = fin && !o_param_error;
   // peer range wins only where range and flag differ and the own flag is set
   function automatic logic [15:0] take(input channel_result_t a, input channel_result_t b);
      logic [15:0] r;
      for (int t = 0; t < `NUM_TRACKS; t++)
         r[4*t+:4] = (a.ranges[t] != b.ranges[t] && a.flags[t] != b.flags[t] && a.flags[t])
                     ? b.ranges[t] : a.ranges[t];
      return r;
   endfunction
   property p_valid;
      $changed(i_referenced) |=> o_cams_valid == $past(i_referenced);
   endproperty
   a_valid: assert property (p_valid) else $error("cams_valid lag wrong");
   property p_scan;
      o_idle && i_monitor_tick && !i_boot_check |-> ##1 (!o_idle)[*8] ##53 !o_idle ##1 o_idle;
   endproperty
   a_scan: assert property (p_scan) else $error("scan length wrong");
   property p_both;
      o_idle && i_boot_check && (|i_function_enable[15:8]) && (|i_track_cam_enable)
         |-> ##61 o_param_error && o_check_done;
   endproperty
   a_both: assert property (p_both) else $error("mixed modes accepted");
   property p_err_zero;
      fin && o_param_error |-> o_diag == '0 && o_safe_cam == '0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("outputs live on error");
   property p_pair_sync;
      ok && i_function_enable[7] |-> o_safe_cam.pair == (o_diag.pair & i_other_channel.pair);
   endproperty
   a_pair_sync: assert property (p_pair_sync) else $error("pair sync wrong");
   property p_pair_own;
      ok && !i_function_enable[7] |-> o_safe_cam.pair == o_diag.pair;
   endproperty
   a_pair_own: assert property (p_pair_own) else $error("pair unsynced wrong");
   property p_flags;
      ok |-> o_safe_cam.flags == (o_diag.flags & i_other_channel.flags);
   endproperty
   a_flags: assert property (p_flags) else $error("track flag sync wrong");
   property p_ranges;
      ok |-> o_safe_cam.ranges == take(o_diag, i_other_channel);
   endproperty
   a_ranges: assert property (p_ranges) else $error("range sync wrong");
   c_flag: cover property (ok && o_diag.flags != 4'h0);
   c_err: cover property (fin && o_param_error);
   c_pair: cover property (ok && o_safe_cam.pair != 8'h00);
endmodule // cam_eval_checker

bind safe_position_cam_evaluator cam_eval_checker u_cam_eval_checker (
   .i_clock, .i_resetn, .i_function_enable, .i_track_cam_enable, .i_referenced,
   .i_monitor_tick, .i_boot_check, .i_other_channel, .o_safe_cam, .o_diag,
   .o_cams_valid, .o_param_error, .o_check_done, .o_idle);

// ---- dv/cam_peer_channel.sv ----
// model of the redundant monitoring channel facing the evaluator
// assumes the bench commands each result before the scan publishes
`timescale 1ns/1ps
module cam_peer_channel
   import cam_eval_pkg::*;
(
   input  wire logic            i_clock,
   input  wire logic            i_resetn,
   input  wire channel_result_t i_command,
   output channel_result_t      o_result
);
   // peer results land on a clock edge; in reset an all-ones pattern
   // stands, unlike any real result, so stale values never pass
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_result <= '1;
      end else begin
         o_result <= i_command;
      end
   end
endmodule // cam_peer_channel

// ---- dv/tb.sv ----
// self-checking bench for the safe cam evaluator: track, sync, boot errors, pairs
// assumes the checker binds itself and the peer model drives the other channel
`timescale 1ns/1ps
module tb;
   import cam_eval_pkg::*;
   logic            i_clock = 1'b0;
   logic            i_resetn = 1'b0;
   logic [15:0]     i_function_enable = 16'h0000;
   logic [29:0]     i_track_cam_enable = 30'h0;
   position_t       i_cam_tolerance = 32'h2;
   position_t       i_position_tolerance = 32'h1;
   position_t       i_modulo_range = 32'h0;
   position_t       i_position = 32'h0;
   logic            i_referenced = 1'b1;
   logic            i_monitor_tick = 1'b0;
   logic            i_boot_check = 1'b0;
   logic            i_cfg_write = 1'b0;
   logic [4:0]      i_cfg_index = 5'h0;
   cam_config_t     i_cfg_data = '0;
   channel_result_t peer_cmd = '0;
   channel_result_t i_other_channel, o_safe_cam, o_diag;
   logic            o_cams_valid, o_param_error, o_check_done, o_channel_mismatch, o_idle;
   int              bad_count = 0;
   int              n_tests = 0;
   safe_position_cam_evaluator u_safe_position_cam_evaluator (
      .i_clock, .i_resetn, .i_function_enable, .i_track_cam_enable, .i_cam_tolerance,
      .i_position_tolerance, .i_modulo_range, .i_position, .i_referenced,
      .i_monitor_tick, .i_boot_check, .i_cfg_write, .i_cfg_index, .i_cfg_data,
      .i_other_channel, .o_safe_cam, .o_diag, .o_cams_valid, .o_param_error,
      .o_check_done, .o_channel_mismatch, .o_idle);
   cam_peer_channel u_cam_peer_channel (.i_clock, .i_resetn, .i_command(peer_cmd),
      .o_result(i_other_channel));
   always #5 i_clock = ~i_clock;
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   // bounded wait; a hang shows up as an idle mismatch
   task automatic wait_idle();
      int n = 0;
      while (o_idle !== 1'b1 && n < 300) begin
         @(negedge i_clock);
         n++;
      end
      chk("idle", 1'b1, o_idle);
   endtask
   task automatic boot(input logic [15:0] fe, input logic [29:0] te, input position_t m,
                       input logic e);
      @(negedge i_clock);
      i_function_enable = fe;
      i_track_cam_enable = te;
      i_modulo_range = m;
      i_boot_check = 1'b1;
      @(negedge i_clock);
      i_boot_check = 1'b0;
      wait_idle();
      chk("param_error", e, o_param_error);
      chk("check_done", 1'b1, o_check_done);
   endtask
   // peer result is set first so it stands through the whole scan
   task automatic scan(input position_t x, input channel_result_t e,
                       input channel_result_t oth, input channel_result_t s);
      @(negedge i_clock);
      peer_cmd = oth;
      i_position = x;
      @(negedge i_clock);
      i_monitor_tick = 1'b1;
      @(negedge i_clock);
      i_monitor_tick = 1'b0;
      wait_idle();
      chk("diag", e, o_diag);
      chk("safe_cam", s, o_safe_cam);
      chk("mismatch", e != oth, o_channel_mismatch);
   endtask
   task automatic se(input position_t x, input channel_result_t e);
      scan(x, e, e, e);
   endtask
   task automatic wcam(input int i, input position_t p, input position_t m, input int a);
      @(negedge i_clock);
      i_cfg_write = 1'b1;
      i_cfg_index = i[4:0];
      i_cfg_data = '{plus_pos: p, minus_pos: m, assignment: a[8:0]};
      @(negedge i_clock);
      i_cfg_write = 1'b0;
   endtask
   // five cams on track 2, one on track 4, a disabled cam on track 3
   task automatic t_track();
      wcam(0, 480, 455, 201);
      wcam(1, 120, 80, 203);
      wcam(2, 320, 300, 202);
      wcam(3, 1000, 900, 414);
      wcam(5, 200, 170, 204);
      wcam(6, 1000, 0, 301);
      wcam(7, 380, 350, 205);
      boot(16'h0000, 30'h000000AF, 0, 1'b0);
      se(50, 28'h000EF3F);
      se(100, 28'h002EF3F);
      se(121, 28'h002EF3F);
      se(123, 28'h000EF4F);
      se(171, 28'h000EF4F);
      se(172, 28'h002EF4F);
      se(310, 28'h002EF2F);
      se(500, 28'h000EFFF);
      se(950, 28'h008EFFF);
      @(negedge i_clock);
      i_referenced = 1'b0;
      repeat (2) @(negedge i_clock);
      chk("cams_valid", 1'b0, o_cams_valid);
      i_referenced = 1'b1;
      repeat (2) @(negedge i_clock);
      chk("cams_valid", 1'b1, o_cams_valid);
   endtask
   task automatic t_sync();
      scan(100, 28'h002EF3F, 28'h0081F5F, 28'h000EF5F);
   endtask
   task automatic t_errors();
      boot(16'h0100, 30'h000000AF, 0, 1'b1);
      scan(100, 28'h0, 28'h0, 28'h0);
      boot(16'h0000, 30'h000000AF, 1000, 1'b1);
      boot(16'h0080, 30'h000000AF, 0, 1'b1);
      wcam(5, 170, 170, 204);
      boot(16'h0000, 30'h000000AF, 0, 1'b1);
      wcam(5, 200, 170, 215);
      boot(16'h0000, 30'h000000AF, 0, 1'b1);
      wcam(5, 200, 170, 504);
      boot(16'h0000, 30'h000000AF, 0, 1'b1);
      wcam(5, 200, 170, 204);
      boot(16'h0000, 30'h000000AF, 0, 1'b0);
   endtask
   // plus cam of pair 0 and minus cam of pair 1 only
   task automatic t_pair();
      wcam(0, 998, -100, 0);
      wcam(1, 200, 50, 0);
      boot(16'h0900, 30'h0, 1000, 1'b0);
      boot(16'h0980, 30'h0, 1000, 1'b1);
      wcam(0, 100, -100, 0);
      boot(16'h0900, 30'h0, 0, 1'b0);
      scan(101, 28'h0100000, 28'h0, 28'h0100000);
      se(0, 28'h0800000);
      boot(16'h0980, 30'h0, 0, 1'b0);
      se(0, 28'h0800000);
      se(51, 28'h0800000);
      se(101, 28'h0);
      scan(103, 28'h0100000, 28'h0, 28'h0);
   endtask
   task automatic end_of_test();
      $display("tests %0d errors %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge i_clock);
      @(negedge i_clock);
      i_resetn = 1'b1;
      chk("idle_reset", 1'b1, o_idle);
      chk("done_reset", 1'b0, o_check_done);
      for (int i = 0; i < 30; i++) wcam(i, 10, 0, 0);
      t_track();
      t_sync();
      t_errors();
      t_pair();
      end_of_test();
   end
   // about 30 scans and boots of 65 cycles each fit well inside this span
   initial begin
      #200000;
      bad_count++;
      end_of_test();
   end
endmodule // tb
